// >>> hw/tmsl_top.sv
// Test mode selection and video signature logic
// Summary of operation
// - Sample read and write strobes when reset is released.
// - A test mode needs read or write strobe low at release.
// - Decode strobes and memory/io select into display test, high, low, tristate.
// - A 16-bit LFSR compresses successive video words into a signature.
// - During blanking the signature replaces pixel data on video pins.
// - Signature readable at frame end through register dump id 3D.
// - Signature is driven onto video pins only in display test mode.
// - Analyzer accumulates only after opcode bit 14 is written one.
// - Drive-high and drive-low force every pin to one or zero.
// - Tristate mode releases every bidirectional pin; video outputs still pass pixel data.
`timescale 1ns/1ps
module tmsl_top #(
    parameter int PIN_N = tmsl_pkg::TMSL_PIN_COUNT
) (
    input  wire logic                                 clk_sys_in,
    input  wire logic                                 sys_rst_in,
    input  wire logic                                 rd_strobe_n_in,
    input  wire logic                                 wr_strobe_n_in,
    input  wire logic                                 memory_io_select_pin_in,
    input  wire logic                                 opcode_wr_in,
    input  wire logic [15:0]                          opcode_data_in,
    input  wire logic                                 blank_in,
    input  wire logic                                 frame_end_in,
    input  wire logic                                 dump_req_in,
    input  wire logic [7:0]                           dump_reg_id_in,
    input  wire logic [tmsl_pkg::TMSL_VIDEO_WIDTH-1:0] video_data_bus_in,
    input  wire logic [PIN_N-1:0]                     pin_data_in,
    input  wire logic [PIN_N-1:0]                     pin_oe_n_in,
    output logic      [tmsl_pkg::TMSL_VIDEO_WIDTH-1:0] video_data_bus_out,
    output logic      [PIN_N-1:0]                     pin_data_out,
    output logic      [PIN_N-1:0]                     pin_oe_n_out,
    output logic      [2:0]                           mode_out,
    output logic                                      dump_valid_out,
    output logic      [tmsl_pkg::TMSL_SIG_WIDTH-1:0]  dump_data_out
);
    import tmsl_pkg::*;

    typedef struct packed {
        logic                        rst_d;
        tmsl_mode_t                  mode;
        logic                        sig_en;
        logic [TMSL_SIG_WIDTH-1:0]   frame_sig;
        logic [TMSL_VIDEO_WIDTH-1:0] video;
        logic [PIN_N-1:0]            pdata;
        logic [PIN_N-1:0]            poe_n;
        logic                        dvalid;
        logic [TMSL_SIG_WIDTH-1:0]   ddata;
    } tmsl_state_t;

    tmsl_state_t                 state_r;
    tmsl_state_t                 state_nxt;
    logic [TMSL_SIG_WIDTH-1:0]   live_sig;
    logic                        is_test;

    // Compressor runs only once software enables it in display test mode
    tmsl_signature #(
        .SIG_W (TMSL_SIG_WIDTH),
        .VID_W (TMSL_VIDEO_WIDTH)
    ) u_sig (
        .clk_sys_in    (clk_sys_in),
        .sys_rst_in    (sys_rst_in),
        .clear_in      (frame_end_in),
        .enable_in     (is_test && state_r.sig_en && !blank_in),
        .video_in      (video_data_bus_in),
        .signature_out (live_sig)
    );

    assign is_test = (state_r.mode == TMSL_MODE_DISP_TEST);

    // Mode capture, signature routing and pin conditioning
    always_comb
    begin
        state_nxt        = state_r;
        state_nxt.rst_d  = 1'b0;
        state_nxt.dvalid = 1'b0;
        // First cycle after release: strobes are sampled exactly once
        if (state_r.rst_d)
        begin
            unique case ({rd_strobe_n_in, wr_strobe_n_in, memory_io_select_pin_in})
                3'b010:  state_nxt.mode = TMSL_MODE_DISP_TEST;
                3'b011:  state_nxt.mode = TMSL_MODE_DRIVE_HIGH;
                3'b100:  state_nxt.mode = TMSL_MODE_DRIVE_LOW;
                3'b101:  state_nxt.mode = TMSL_MODE_TRISTATE;
                3'b110,
                3'b111:  state_nxt.mode = TMSL_MODE_NORMAL;
                default: state_nxt.mode = TMSL_MODE_RESERVED;
            endcase
        end
        // Enable bit tracks opcode writes; only meaningful in test mode
        if (opcode_wr_in && is_test)
            state_nxt.sig_en = opcode_data_in[TMSL_ENABLE_BIT];
        // Snapshot at frame end so the dump reads a stable value
        if (frame_end_in)
            state_nxt.frame_sig = live_sig;
        if (dump_req_in && dump_reg_id_in == TMSL_SIG_REG_ID)
        begin
            state_nxt.dvalid = 1'b1;
            state_nxt.ddata  = state_r.frame_sig;
        end
        // Video path: signature replaces pixels in blanking, test mode only
        if (is_test && blank_in)
            state_nxt.video = live_sig[TMSL_VIDEO_WIDTH-1:0];
        else
            state_nxt.video = video_data_bus_in;
        // Conditioning overrides the functional pin drive
        unique case (state_r.mode)
            TMSL_MODE_DRIVE_HIGH:
            begin
                state_nxt.pdata = '1;
                state_nxt.poe_n = '0;
                state_nxt.video = '1;
            end
            TMSL_MODE_DRIVE_LOW:
            begin
                state_nxt.pdata = '0;
                state_nxt.poe_n = '0;
                state_nxt.video = '0;
            end
            TMSL_MODE_TRISTATE:
            begin
                state_nxt.pdata = '0;
                state_nxt.poe_n = '1;
            end
            default:
            begin
                state_nxt.pdata = pin_data_in;
                state_nxt.poe_n = pin_oe_n_in;
            end
        endcase
    end

    // Reset holds mode at normal with all pins released
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            state_r       <= '0;
            state_r.rst_d <= 1'b1;
            state_r.mode  <= TMSL_MODE_NORMAL;
            state_r.poe_n <= '1;
        end
        else
            state_r <= state_nxt;
    end

    assign video_data_bus_out = state_r.video;
    assign pin_data_out       = state_r.pdata;
    assign pin_oe_n_out       = state_r.poe_n;
    assign mode_out           = state_r.mode;
    assign dump_valid_out     = state_r.dvalid;
    assign dump_data_out      = state_r.ddata;

    a_mode_held: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        !state_r.rst_d |=> $stable(state_r.mode)) else $error("mode changed");
    a_mode_decode: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        state_r.rst_d && rd_strobe_n_in && wr_strobe_n_in
        |=> mode_out == TMSL_MODE_NORMAL) else $error("normal decode");
    a_disp_decode: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        state_r.rst_d && {rd_strobe_n_in, wr_strobe_n_in, memory_io_select_pin_in} == 3'b010
        |=> is_test) else $error("display test decode");
    a_sig_video: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        is_test && blank_in |=> video_data_bus_out == $past(live_sig[7:0]))
        else $error("signature not on video");
    a_no_sig_norm: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        state_r.mode == TMSL_MODE_NORMAL |=> video_data_bus_out == $past(video_data_bus_in))
        else $error("signature in normal");
    a_drive_high: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        state_r.mode == TMSL_MODE_DRIVE_HIGH |=> pin_data_out == '1 && pin_oe_n_out == '0)
        else $error("drive high");
    a_drive_low: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        state_r.mode == TMSL_MODE_DRIVE_LOW |=> pin_data_out == '0 && pin_oe_n_out == '0)
        else $error("drive low");
    a_tristate: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        state_r.mode == TMSL_MODE_TRISTATE |=> pin_oe_n_out == '1)
        else $error("tristate");
    a_dump_sig: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        frame_end_in ##1 (dump_req_in && dump_reg_id_in == TMSL_SIG_REG_ID && !frame_end_in)
        |=> dump_valid_out && dump_data_out == $past(live_sig, 2))
        else $error("dump value");
    a_sig_idle: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        !state_r.sig_en && !frame_end_in |=> $stable(live_sig))
        else $error("signature moved");
    a_sig_update: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        is_test && state_r.sig_en && !blank_in && !frame_end_in && video_data_bus_in != 8'h00
        && live_sig[15] == 1'b0 |=> live_sig != {$past(live_sig[14:0]), 1'b0})
        else $error("video not folded");

    // Remaining strap codes; every legal pattern has its own check
    a_high_decode: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        state_r.rst_d && {rd_strobe_n_in, wr_strobe_n_in, memory_io_select_pin_in} == 3'b011
        |=> mode_out == TMSL_MODE_DRIVE_HIGH) else $error("drive high decode");
    a_low_decode: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        state_r.rst_d && {rd_strobe_n_in, wr_strobe_n_in, memory_io_select_pin_in} == 3'b100
        |=> mode_out == TMSL_MODE_DRIVE_LOW) else $error("drive low decode");
    a_tri_decode: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        state_r.rst_d && {rd_strobe_n_in, wr_strobe_n_in, memory_io_select_pin_in} == 3'b101
        |=> mode_out == TMSL_MODE_TRISTATE) else $error("tristate decode");
    a_rsvd_decode: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        state_r.rst_d && !rd_strobe_n_in && !wr_strobe_n_in
        |=> mode_out == TMSL_MODE_RESERVED) else $error("reserved decode");
    // Reserved codes behave as normal: pixels only on the video pins
    a_rsvd_video: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        state_r.mode == TMSL_MODE_RESERVED |=> video_data_bus_out == $past(video_data_bus_in))
        else $error("signature in reserved");
    // Analyzer enable follows opcode writes and exists only in test mode
    a_en_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        is_test && opcode_wr_in |=> state_r.sig_en == $past(opcode_data_in[TMSL_ENABLE_BIT]))
        else $error("enable not written");
    a_en_test_only: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        !is_test |-> !state_r.sig_en)
        else $error("enable outside test");
    // Blanking freezes the analyzer so the shown value covers the whole line
    a_blank_hold: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        blank_in && !frame_end_in |=> $stable(live_sig))
        else $error("signature moved in blank");
    // Frame end restarts the analyzer for the next frame
    a_frame_clear: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        frame_end_in |=> live_sig == TMSL_SIG_RESET)
        else $error("signature not cleared");
    // Dump for any other register id stays silent
    a_dump_other: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        dump_req_in && dump_reg_id_in != TMSL_SIG_REG_ID |=> !dump_valid_out)
        else $error("dump on wrong id");
endmodule : tmsl_top

// >>> hw/tmsl_pkg.sv
// Package of constants and types for the test mode and signature logic
package tmsl_pkg;
    // Test mode decoded at reset release
    typedef enum logic [2:0] {
        TMSL_MODE_NORMAL,
        TMSL_MODE_DISP_TEST,
        TMSL_MODE_DRIVE_HIGH,
        TMSL_MODE_DRIVE_LOW,
        TMSL_MODE_TRISTATE,
        TMSL_MODE_RESERVED
    } tmsl_mode_t;

    localparam int          TMSL_SIG_WIDTH    = 16;
    localparam int          TMSL_VIDEO_WIDTH  = 8;
    localparam int          TMSL_PIN_COUNT    = 32;
    localparam int          TMSL_ENABLE_BIT   = 14;
    localparam logic [7:0]  TMSL_SIG_REG_ID   = 8'h3D;
    localparam logic [15:0] TMSL_SIG_RESET    = 16'h0000;
    // Feedback taps x^16+x^12+x^3+x+1
    localparam logic [15:0] TMSL_SIG_TAPS     = 16'h100B;
endpackage : tmsl_pkg

// >>> hw/tmsl_signature.sv
// Signature shift register compressing the video data stream
`timescale 1ns/1ps
module tmsl_signature #(
    parameter int SIG_W = 16,
    parameter int VID_W = 8
) (
    input  wire logic             clk_sys_in,
    input  wire logic             sys_rst_in,
    input  wire logic             clear_in,
    input  wire logic             enable_in,
    input  wire logic [VID_W-1:0] video_in,
    output logic      [SIG_W-1:0] signature_out
);
    import tmsl_pkg::*;

    typedef struct packed {
        logic [SIG_W-1:0] sig;
    } tmsl_sig_state_t;

    tmsl_sig_state_t state_r;
    tmsl_sig_state_t state_nxt;
    logic            fb;

    // Shift with feedback, then fold the video word in (multi-input LFSR)
    always_comb
    begin
        state_nxt = state_r;
        fb        = state_r.sig[SIG_W-1];
        if (clear_in)
        begin
            state_nxt.sig = SIG_W'(TMSL_SIG_RESET);
        end
        else if (enable_in)
        begin
            state_nxt.sig = {state_r.sig[SIG_W-2:0], 1'b0}
                ^ (fb ? SIG_W'(TMSL_SIG_TAPS) : '0)
                ^ SIG_W'(video_in);
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
            state_r <= '0;
        else
            state_r <= state_nxt;
    end

    assign signature_out = state_r.sig;
endmodule : tmsl_signature

// >>> testbench/tmsl_tester.sv
// Tester model holding strap levels across reset release
`timescale 1ns/1ps
module tmsl_tester (
    input  wire logic       clk_sys_in,
    input  wire logic [2:0] code_in,
    output logic            rd_strobe_n_out,
    output logic            wr_strobe_n_out,
    output logic            memory_io_select_pin_out
);
    // Levels move only after an edge, so they stand steady at reset release
    always_ff @(posedge clk_sys_in)
    begin
        {rd_strobe_n_out, wr_strobe_n_out, memory_io_select_pin_out} <= code_in;
    end
endmodule : tmsl_tester

// >>> testbench/tmsl_top_tb.sv
// Self-checking bench for the test mode and signature logic
`timescale 1ns/1ps
module tmsl_top_tb;
    import tmsl_pkg::*;
    logic        clk_sys_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic [2:0]  code       = 3'b110;
    logic        rd_n, wr_n, memory_io_select_pin, dval, opc_wr = 1'b0, blank = 1'b0, fend = 1'b0, dreq = 1'b0;
    logic [15:0] opc        = 16'h0000;
    logic [15:0] ddat, sig;
    logic [7:0]  did        = 8'h00;
    logic [7:0]  vid        = 8'h00;
    logic [7:0]  vout;
    logic [31:0] pdat       = 32'h0000_0000;
    logic [31:0] poe        = 32'hFFFF_FFFF;
    logic [31:0] pdo, poo;
    logic [2:0]  mode;
    int          miscompares = 0;
    int          comparisons = 0;
    // Expected mode per strap code {rd, wr, select}
    tmsl_mode_t  exp_mode [8] = '{TMSL_MODE_RESERVED, TMSL_MODE_RESERVED,
        TMSL_MODE_DISP_TEST, TMSL_MODE_DRIVE_HIGH, TMSL_MODE_DRIVE_LOW,
        TMSL_MODE_TRISTATE, TMSL_MODE_NORMAL, TMSL_MODE_NORMAL};

    tmsl_tester i_tmsl_tester (.clk_sys_in(clk_sys_in), .code_in(code), .rd_strobe_n_out(rd_n),
        .wr_strobe_n_out(wr_n), .memory_io_select_pin_out(memory_io_select_pin));
    tmsl_top i_tmsl_top (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .rd_strobe_n_in(rd_n), .wr_strobe_n_in(wr_n), .memory_io_select_pin_in(memory_io_select_pin),
        .opcode_wr_in(opc_wr), .opcode_data_in(opc), .blank_in(blank), .frame_end_in(fend),
        .dump_req_in(dreq), .dump_reg_id_in(did), .video_data_bus_in(vid),
        .pin_data_in(pdat), .pin_oe_n_in(poe), .video_data_bus_out(vout),
        .pin_data_out(pdo), .pin_oe_n_out(poo), .mode_out(mode),
        .dump_valid_out(dval), .dump_data_out(ddat));

    // Clock at 50 MHz
    initial
    begin
        forever #10 clk_sys_in = ~clk_sys_in;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Shift register step as the bench expects it
    function automatic logic [15:0] fold(input logic [15:0] s, input logic [7:0] v);
        return {s[14:0], 1'b0} ^ (s[15] ? TMSL_SIG_TAPS : 16'h0000) ^ {8'h00, v};
    endfunction : fold

    // Reset for 3 cycles with the strap code held, then wait until mode settles
    task automatic strap(input logic [2:0] c);
        @(posedge clk_sys_in);
        sys_rst_in <= 1'b1;
        code       <= c;
        repeat (3) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        #1;
    endtask : strap

    task automatic test_strap_modes;
        blank <= 1'b1;
        vid   <= 8'hA5;
        pdat  <= 32'h1234_5678;
        poe   <= 32'h0000_FFFF;
        for (int c = 0; c < 8; c++)
        begin
            strap(c[2:0]);
            chk("mode", 32'(exp_mode[c]), 32'(mode));
            // Strap pins flip afterwards; mode must not follow
            @(posedge clk_sys_in);
            code <= ~c[2:0];
            repeat (3) @(posedge clk_sys_in);
            #1;
            chk("mode held", 32'(exp_mode[c]), 32'(mode));
            chk("pin oe_n", (c == 3 || c == 4) ? 32'h0000_0000 :
                (c == 5) ? 32'hFFFF_FFFF : 32'h0000_FFFF, poo);
            if (c != 5)
                chk("pin data", (c == 3) ? 32'hFFFF_FFFF : (c == 4) ? 32'h0000_0000 :
                    32'h1234_5678, pdo);
            chk("video", (c == 3) ? 32'h0000_00FF : (c == 4 || c == 2) ? 32'h0000_0000 :
                32'h0000_00A5, 32'(vout));
        end
        $display("test strap_modes done");
    endtask : test_strap_modes

    task automatic test_signature;
        logic [7:0] w [4] = '{8'h3C, 8'h81, 8'hF0, 8'h5A};
        sig = TMSL_SIG_RESET;
        for (int i = 0; i < 4; i++)
            sig = fold(sig, w[i]);
        strap(3'b010);
        // Traffic before enabling must not be folded in
        @(posedge clk_sys_in);
        blank <= 1'b0;
        vid   <= 8'h5A;
        repeat (3) @(posedge clk_sys_in);
        opc_wr <= 1'b1;
        opc    <= 16'h4000;
        vid    <= 8'h00;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk_sys_in);
            opc_wr <= 1'b0;
            vid    <= w[i];
        end
        @(posedge clk_sys_in);
        blank <= 1'b1;
        vid   <= 8'hC3;
        @(posedge clk_sys_in);
        #1;
        chk("blank signature", 32'(sig[7:0]), 32'(vout));
        @(posedge clk_sys_in);
        fend <= 1'b1;
        @(posedge clk_sys_in);
        fend <= 1'b0;
        dreq <= 1'b1;
        did  <= 8'h3C;
        @(posedge clk_sys_in);
        did <= 8'h3D;
        #1;
        chk("wrong id valid", 32'h0000_0000, 32'(dval));
        chk("cleared signature", 32'h0000_0000, 32'(vout));
        @(posedge clk_sys_in);
        dreq <= 1'b0;
        #1;
        chk("dump valid", 32'h0000_0001, 32'(dval));
        chk("dump data", 32'(sig), 32'(ddat));
        @(posedge clk_sys_in);
        #1;
        chk("dump valid end", 32'h0000_0000, 32'(dval));
        chk("dump data held", 32'(sig), 32'(ddat));
        // Second frame with no traffic: dump right after frame end sees a cleared analyzer
        @(posedge clk_sys_in);
        fend <= 1'b1;
        @(posedge clk_sys_in);
        fend <= 1'b0;
        dreq <= 1'b1;
        @(posedge clk_sys_in);
        dreq <= 1'b0;
        #1;
        chk("second dump", {15'h0000, 1'b1, TMSL_SIG_RESET}, {15'h0000, dval, ddat});
        $display("test signature done");
    endtask : test_signature

    task automatic results;
        $display("Comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    // Watchdog: a hang counts as a mismatch
    initial
    begin
        repeat (2000) @(posedge clk_sys_in);
        miscompares++;
        results();
    end

    initial
    begin
        test_strap_modes();
        test_signature();
        results();
    end
endmodule : tmsl_top_tb
